// >>> hw/decoder_status_and_setup_pins.sv
// Status pin muxing, field-memory strobes, straps and gain/input setup with an APB slave.
`timescale 1ns/10ps
`include "decoder_setup_map.svh"

module decoder_status_and_setup_pins
  import decoder_setup_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Internal decoder status, same clock.
  input  wire logic        fifo_overflow,
  input  wire logic        composite_sync,
  input  wire logic        pal_detected,
  input  wire logic        horizontal_lock,
  input  wire logic        vbi_data_detected,
  // Internal field-memory strobes, same clock.
  input  wire logic        read_strobe_int,
  input  wire logic        write_strobe_int,
  input  wire logic        read_ptr_clear_int,
  input  wire logic        write_ptr_clear_int,
  // Board straps and setup pins, asynchronous.
  input  wire logic        fm_enable_strap,
  input  wire logic        addr_strap,
  input  wire logic        setup_src_strap,
  input  wire logic [2:0]  gain_select_pins,
  input  wire logic [2:0]  input_select_pins,
  // Status pins and memory control bus.
  output logic [3:1]       status,
  output logic [7:3]       mem_ctrl,
  output logic [3:0]       mem_ctrl_oe,
  // Setup towards the analog front end.
  output logic [2:0]       manual_gain_value,
  output logic [2:0]       input_channel,
  output logic             gain_undefined,
  output logic             svideo_mode,
  output logic             converter_sleep,
  output logic [6:0]       slave_address,
  // Interrupt.
  output logic             irq
);

  // ****************************************
  // Synchronisers
  // ****************************************
  // Straps and setup pins come from the board and pass two flops first.
  logic [8:0] sync_meta;
  logic [8:0] sync_pins;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta <= 9'h000;
      sync_pins <= 9'h000;
    end else begin
      sync_meta <= {fm_enable_strap, addr_strap, setup_src_strap,
                    gain_select_pins, input_select_pins};
      sync_pins <= sync_meta;
    end
  end

  wire         fm_en_s      = sync_pins[8];
  wire         addr_s       = sync_pins[7];
  wire         src_s        = sync_pins[6];
  wire code3_t gain_pins_s  = sync_pins[5:3];
  wire code3_t input_pins_s = sync_pins[2:0];

  // ****************************************
  // Code decoding
  // ****************************************
  // Shared by the output logic and the checks, so both read the codes alike.
  function automatic logic gain_is_undefined(input code3_t code);
    return code == `GAIN_UNDEFINED;
  endfunction

  function automatic logic input_is_separate(input code3_t code);
    return (code == `INPUT_SV1) || (code == `INPUT_SV2);
  endfunction

  function automatic logic input_is_prohibited(input code3_t code);
    return code == `INPUT_PROHIBITED;
  endfunction

  function automatic logic [6:0] address_for(input logic strap);
    return strap ? `SLAVE_ADDR_STRAP1 : `SLAVE_ADDR_STRAP0;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [1:0] status_select_register;
  logic [7:0] converter_ctrl_first;
  logic [7:0] converter_ctrl_second;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;

  wire apb_access = psel && penable;
  wire apb_write  = apb_access && pwrite;
  wire hit_sel    = (paddr == `OFS_STATUS_SELECT);
  wire hit_c1     = (paddr == `OFS_CONV_FIRST);
  wire hit_c2     = (paddr == `OFS_CONV_SECOND);
  wire hit_ist    = (paddr == `OFS_IRQ_STATUS);
  wire hit_imk    = (paddr == `OFS_IRQ_MASK);
  wire hit_live   = (paddr == `OFS_LIVE_STATUS);
  wire hit_addr   = (paddr == `OFS_SLAVE_ADDR);
  wire hit_any    = hit_sel || hit_c1 || hit_c2 || hit_ist || hit_imk || hit_live || hit_addr;

  // ****************************************
  // Setup source selection
  // ****************************************
  // In pin mode the register fields are simply not selected, so writes still store.
  setup_source_t setup_source;
  assign setup_source = src_s ? src_register : src_pins;
  wire code3_t reg_gain  = converter_ctrl_second[`GAIN_HI:`GAIN_LO];
  wire code3_t reg_input = converter_ctrl_first[`INPUT_HI:`INPUT_LO];
  wire code3_t sel_gain  = (setup_source == src_register) ? reg_gain : gain_pins_s;
  wire code3_t sel_input = (setup_source == src_register) ? reg_input : input_pins_s;
  wire         next_gain_undef = gain_is_undefined(sel_gain);
  wire         next_sleep      = input_is_prohibited(sel_input);
  wire         next_svideo     = input_is_separate(sel_input);

  // ****************************************
  // Status and memory bus
  // ****************************************
  wire [3:1] next_status;
  assign next_status[3] = status_select_register[`BIT_SEL_STATUS3] ?
                          composite_sync : fifo_overflow;
  assign next_status[2] = status_select_register[`BIT_SEL_STATUS2] ?
                          horizontal_lock : pal_detected;
  assign next_status[1] = vbi_data_detected;
  wire [3:0] strobes = {read_strobe_int, write_strobe_int,
                        read_ptr_clear_int, write_ptr_clear_int};
  // Outside field-memory mode the strobes are held low and undriven.
  wire [3:0] next_mem = fm_en_s ? strobes : 4'h0;

  // ****************************************
  // Interrupt
  // ****************************************
  // Sources are levels, so a bit keeps setting for as long as its source stays high.
  wire [3:0] events = {next_sleep, horizontal_lock, vbi_data_detected, fifo_overflow};
  wire [3:0] clr    = (apb_write && hit_ist) ? pwdata[3:0] : 4'h0;
  // Set wins over a clear written in the same cycle.
  wire [3:0] next_irq_status = (irq_status & ~clr) | events;

  // ****************************************
  // Register bus
  // ****************************************
  // Read data are taken in the setup cycle, so no transfer ever needs a wait state.
  wire [31:0] rd_word =
      hit_sel  ? {30'h0, status_select_register} :
      hit_c1   ? {24'h0, converter_ctrl_first} :
      hit_c2   ? {24'h0, converter_ctrl_second} :
      hit_ist  ? {28'h0, irq_status} :
      hit_imk  ? {28'h0, irq_mask} :
      hit_live ? {23'h0, fm_en_s, src_s, next_sleep, svideo_mode, status, 2'h0} :
      hit_addr ? {25'h0, slave_address} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_select_register <= `RST_STATUS_SELECT;
      converter_ctrl_first   <= `RST_CONV;
      converter_ctrl_second  <= `RST_CONV;
      irq_mask               <= `RST_IRQ_MASK;
    end else if (apb_write) begin
      if (hit_sel) begin
        status_select_register <= pwdata[1:0];
      end else if (hit_c1) begin
        converter_ctrl_first <= pwdata[7:0];
      end else if (hit_c2) begin
        converter_ctrl_second <= pwdata[7:0];
      end else if (hit_imk) begin
        irq_mask <= pwdata[3:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable) ? rd_word : prdata;
      pslverr <= psel && !penable && !hit_any;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status      <= 3'h0;
      mem_ctrl    <= 5'h00;
      mem_ctrl_oe <= 4'h0;
    end else begin
      status      <= next_status;
      mem_ctrl    <= {next_mem, 1'b0};
      mem_ctrl_oe <= {4{fm_en_s}};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      manual_gain_value <= 3'h0;
      input_channel     <= 3'h0;
      gain_undefined    <= 1'b0;
      svideo_mode       <= 1'b0;
      converter_sleep   <= 1'b0;
    end else begin
      manual_gain_value <= sel_gain;
      input_channel     <= sel_input;
      gain_undefined    <= next_gain_undef;
      svideo_mode       <= next_svideo;
      converter_sleep   <= next_sleep;
    end
  end

  // A strap change on a live board reaches the address three cycles later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_address <= `SLAVE_ADDR_STRAP0;
    end else begin
      slave_address <= address_for(addr_s);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 4'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq        <= |(next_irq_status & irq_mask);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_status3_mux: assert property (@(posedge pclk) disable iff (!presetn)
    !status_select_register[0] |=> status[3] == $past(fifo_overflow))
    else $error("status3 not overflow");
  a_status3_composite_sync: assert property (@(posedge pclk) disable iff (!presetn)
    status_select_register[0] |=> status[3] == $past(composite_sync))
    else $error("status3 not composite_sync");
  a_status2_std: assert property (@(posedge pclk) disable iff (!presetn)
    !status_select_register[1] |=> status[2] == $past(pal_detected))
    else $error("status2 not standard");
  a_status2_lock: assert property (@(posedge pclk) disable iff (!presetn)
    status_select_register[1] |=> status[2] == $past(horizontal_lock))
    else $error("status2 not lock");
  a_status1_vbi: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 status[1] == $past(vbi_data_detected))
    else $error("status1 not vbi");
  a_mem_gated: assert property (@(posedge pclk) disable iff (!presetn)
    !fm_en_s |=> mem_ctrl[7:4] == 4'h0 && mem_ctrl_oe == 4'h0)
    else $error("strobes active while disabled");
  a_mem_pass: assert property (@(posedge pclk) disable iff (!presetn)
    fm_en_s |=> mem_ctrl[7:4] == $past(strobes))
    else $error("strobes not passed");
  a_test_low: assert property (@(posedge pclk) disable iff (!presetn)
    mem_ctrl[3] == 1'b0)
    else $error("test bit high");
  a_slave_addr: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 slave_address == address_for($past(addr_s)))
    else $error("slave address wrong");
  a_pin_mode: assert property (@(posedge pclk) disable iff (!presetn)
    !src_s |=> manual_gain_value == $past(gain_pins_s) && input_channel == $past(input_pins_s))
    else $error("pin mode ignored");
  a_sleep_code: assert property (@(posedge pclk) disable iff (!presetn)
    input_is_prohibited(sel_input) |=> converter_sleep)
    else $error("no sleep on prohibited code");

  // ****************************************
  // Assertions: setup decoding, strobe enables and strap synchronisers
  // ****************************************
  a_reg_mode: assert property (@(posedge pclk) disable iff (!presetn)
    src_s |=> manual_gain_value == $past(converter_ctrl_second[`GAIN_HI:`GAIN_LO])
    && input_channel == $past(converter_ctrl_first[`INPUT_HI:`INPUT_LO]))
    else $error("register mode ignored");
  a_gain_flag: assert property (@(posedge pclk) disable iff (!presetn)
    gain_undefined == gain_is_undefined(manual_gain_value))
    else $error("gain undefined flag wrong");
  a_svideo_flag: assert property (@(posedge pclk) disable iff (!presetn)
    svideo_mode == input_is_separate(input_channel))
    else $error("separate input flag wrong");
  a_sleep_flag: assert property (@(posedge pclk) disable iff (!presetn)
    converter_sleep == input_is_prohibited(input_channel))
    else $error("sleep flag wrong");
  a_oe_follow: assert property (@(posedge pclk) disable iff (!presetn)
    fm_en_s |=> &mem_ctrl_oe)
    else $error("strobes not driven");
  a_strap_sync: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 {fm_en_s, addr_s, src_s} == $past({fm_enable_strap, addr_strap, setup_src_strap}, 2))
    else $error("strap synchroniser latency");

  // ****************************************
  // Assertions: register bus
  // ****************************************
  a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !hit_any |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && hit_any |=> !pslverr)
    else $error("error on mapped access");
  a_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && !penable) |=> $stable(prdata))
    else $error("read data moved");
  a_write_select: assert property (@(posedge pclk) disable iff (!presetn)
    apb_write && hit_sel |=> status_select_register == $past(pwdata[1:0]))
    else $error("select write lost");
  a_write_conv1: assert property (@(posedge pclk) disable iff (!presetn)
    apb_write && hit_c1 |=> converter_ctrl_first == $past(pwdata[7:0]))
    else $error("first converter write lost");
  a_write_conv2: assert property (@(posedge pclk) disable iff (!presetn)
    apb_write && hit_c2 |=> converter_ctrl_second == $past(pwdata[7:0]))
    else $error("second converter write lost");
  a_write_mask: assert property (@(posedge pclk) disable iff (!presetn)
    apb_write && hit_imk |=> irq_mask == $past(pwdata[3:0]))
    else $error("mask write lost");
  a_no_write: assert property (@(posedge pclk) disable iff (!presetn)
    !apb_write |=> $stable(converter_ctrl_first) && $stable(converter_ctrl_second))
    else $error("control changed without write");

  // ****************************************
  // Assertions: interrupt
  // ****************************************
  a_irq_set: assert property (@(posedge pclk) disable iff (!presetn)
    (|events) |=> (irq_status & $past(events)) == $past(events))
    else $error("event lost");
  a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (|(clr & ~events)) |=> (irq_status & $past(clr & ~events)) == 4'h0)
    else $error("status not cleared");
  a_irq_hold: assert property (@(posedge pclk) disable iff (!presetn)
    clr == 4'h0 |=> (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("status bit dropped");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |(irq_status & $past(irq_mask)))
    else $error("interrupt level wrong");

endmodule

// >>> hw/decoder_setup_map.svh
// Register offsets, field positions, reset values and codes of the decoder setup block.
`ifndef DECODER_SETUP_MAP_SVH
`define DECODER_SETUP_MAP_SVH
`define OFS_STATUS_SELECT  12'h000
`define OFS_CONV_FIRST     12'h004
`define OFS_CONV_SECOND    12'h008
`define OFS_IRQ_STATUS     12'h00c
`define OFS_IRQ_MASK       12'h010
`define OFS_LIVE_STATUS    12'h014
`define OFS_SLAVE_ADDR     12'h018
`define RST_STATUS_SELECT  2'h0
`define RST_CONV           8'h00
`define RST_IRQ_MASK       4'h0
`define BIT_SEL_STATUS3    0
`define BIT_SEL_STATUS2    1
`define GAIN_HI            6
`define GAIN_LO            4
`define INPUT_HI           2
`define INPUT_LO           0
`define SLAVE_ADDR_STRAP0  7'h41
`define SLAVE_ADDR_STRAP1  7'h43
`define GAIN_UNDEFINED     3'h7
`define INPUT_PROHIBITED   3'h7
`define INPUT_SV1          3'h5
`define INPUT_SV2          3'h6
`define IRQ_OVERFLOW       0
`define IRQ_VBI            1
`define IRQ_HORIZONTAL_LOCK          2
`define IRQ_BADCODE        3
`endif

// >>> hw/decoder_setup_pkg.sv
// Types shared by the decoder status and setup logic.
package decoder_setup_pkg;
  typedef enum logic [1:0] {
    src_pins     = 2'b00,
    src_register = 2'b01
  } setup_source_t;
  typedef logic [2:0] code3_t;
endpackage

// >>> testbench/field_memory_model.sv
// Model of the external field memory and its board strap on the memory control bus.
`timescale 1ns/10ps
module field_memory_model (
  // Clock and board fitting.
  input  wire logic       pclk,
  input  wire logic       fitted,
  // Memory control bus.
  input  wire logic [7:3] mem_ctrl,
  input  wire logic [3:0] mem_ctrl_oe,
  // Strap and activity count.
  output logic            fm_enable_strap,
  output int              writes
);
  // A board without the memory ties the enable strap low.
  assign fm_enable_strap = fitted;
  initial writes = 0;
  // Write strobes count only while the bus is driven, as undriven lines mean nothing.
  always @(posedge pclk) if (mem_ctrl_oe[2] && mem_ctrl[6]) writes <= writes + 1;
endmodule

// >>> testbench/decoder_status_and_setup_pins_test.sv
// Self-checking bench for the decoder status and setup block.
`timescale 1ns/10ps
module decoder_status_and_setup_pins_test;
  import decoder_setup_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, probe = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, v;
  logic        pready, pslverr, irq, ovf = 0, cs = 0, pal = 0, hl = 0, vbi = 0, fitted = 0;
  logic        rs = 0, ws = 0, rc = 0, wc = 0, fm, as = 0, ss = 0, gu, sv, sl, eirq = 0;
  logic [2:0]  gp = 0, ip = 0, g, ch;
  logic [3:1]  status;
  logic [7:3]  mem_ctrl;
  logic [3:0]  oe;
  logic [6:0]  sa;
  logic [1:0]  sel = 0;
  logic [7:0]  cf1 = 0, cf2 = 0;
  logic [15:0] rnd = 16'h0001;
  logic [32:0] q[$], e;
  int          err_count = 0, check_count = 0, cyc = 0;
  wire  [28:0] pins = {status, mem_ctrl, oe, g, ch, gu, sv, sl, sa, irq};

  always #2.5 pclk = ~pclk;

  decoder_status_and_setup_pins dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .fifo_overflow(ovf), .composite_sync(cs),
    .pal_detected(pal), .horizontal_lock(hl), .vbi_data_detected(vbi), .read_strobe_int(rs),
    .write_strobe_int(ws), .read_ptr_clear_int(rc), .write_ptr_clear_int(wc),
    .fm_enable_strap(fm), .addr_strap(as), .setup_src_strap(ss), .gain_select_pins(gp),
    .input_select_pins(ip), .status(status), .mem_ctrl(mem_ctrl), .mem_ctrl_oe(oe),
    .manual_gain_value(g), .input_channel(ch), .gain_undefined(gu), .svideo_mode(sv),
    .converter_sleep(sl), .slave_address(sa), .irq(irq));

  field_memory_model fmem (.pclk(pclk), .fitted(fitted), .mem_ctrl(mem_ctrl),
    .mem_ctrl_oe(oe), .fm_enable_strap(fm), .writes());

  function automatic logic [28:0] expv();
    logic [2:0] eg, ec;
    eg = ss ? cf2[6:4] : gp;
    ec = ss ? cf1[2:0] : ip;
    return {sel[0] ? cs : ovf, sel[1] ? hl : pal, vbi, fm ? {rs, ws, rc, wc} : 4'h0, 1'b0,
      {4{fm}}, eg, ec, eg == 3'h7, ec == 3'h5 || ec == 3'h6, ec == 3'h7,
      as ? 7'h43 : 7'h41, eirq};
  endfunction

  // Sixteen shifts per call, so that every bit handed out is fresh.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    for (int k = 0; k < 16; k++) s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    return s;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    q.push_back({1'b0, x});
    apb(0, a, 32'h0);
  endtask

  task automatic chk_pins();
    repeat (5) @(posedge pclk);
    q.push_back({4'h8, expv()});
    probe <= 1;
    @(posedge pclk);
    probe <= 0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // Result watcher.
  // ****************************************
  always @(posedge pclk) begin
    if (probe || (psel && penable && pready && !pwrite)) begin
      e = q.pop_front();
      v = probe ? {3'h0, pins} : prdata;
      check_count++;
      if (v !== e[31:0]) begin
        err_count++;
        $display("MISMATCH %s expected %h seen %h", probe ? "pins" : "prdata", e[31:0], v);
      end
    end
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Scenarios.
  // ****************************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rd(12'h000, 0);
    rd(12'h004, 0);
    rd(12'h008, 0);
    rd(12'h010, 0);
    rd(12'h018, 32'h41);
    rd(12'h01c, 0);
    $display("test reset_values done");
    // Random sources, strobes and straps under every status selection.
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      sel = i[1:0];
      apb(1, 12'h000, {30'h0, sel});
      {ovf, cs, pal, hl, vbi, rs, ws, rc, wc, fitted, as} <= rnd[10:0];
      chk_pins();
    end
    $display("test status_and_strobes done");
    // Every code from pins and from registers; code seven on purpose, to see the sleep.
    for (int i = 0; i < 16; i++) begin
      cf1 = {5'h0, ~i[2:0]};
      cf2 = {1'b0, ~i[2:0], 4'h0};
      apb(1, 12'h004, {24'h0, cf1});
      apb(1, 12'h008, {24'h0, cf2});
      ss <= i[3];
      gp <= i[2:0];
      ip <= i[2:0] + 3'h1;
      chk_pins();
    end
    $display("test setup_source done");
    {ovf, cs, pal, hl, vbi, ss, ip} <= 0;
    chk_pins();
    rd(12'h014, {23'h0, fitted, 8'h00});
    apb(1, 12'h00c, 32'hf);
    rd(12'h00c, 0);
    ovf <= 1;
    @(posedge pclk);
    ovf <= 0;
    rd(12'h00c, 32'h1);
    apb(1, 12'h010, 32'h1);
    eirq = 1;
    chk_pins();
    apb(1, 12'h00c, 32'h1);
    eirq = 0;
    chk_pins();
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule
